//--- rtl/fspsc_map.svh
`ifndef FSPSC_MAP_SVH
`define FSPSC_MAP_SVH
// ------------------------------------------------------------------
// Flash geometry and timing
// ------------------------------------------------------------------
`define FSPSC_ADDR_W 12
`define FSPSC_HALT_BASE 12'hC00
`define FSPSC_BOOT_BASE_0 12'hF80
`define FSPSC_BOOT_BASE_1 12'hF00
`define FSPSC_BOOT_BASE_2 12'hE00
`define FSPSC_BOOT_BASE_3 12'hC00
`define FSPSC_PROG_TIME_NS 4500000
`define FSPSC_CLK_NS 40
`define FSPSC_PROG_CYC (`FSPSC_PROG_TIME_NS / `FSPSC_CLK_NS)
`define FSPSC_CNT_W 20
`define FSPSC_LOCK_FREE 2'h3
`define FSPSC_LOCK_NOWR 1'h0
`endif

//--- rtl/fspsc_pkg.sv
package fspsc_pkg;
`include "fspsc_map.svh"
    typedef struct packed {
        logic valid;
        logic erase;
        logic [`FSPSC_ADDR_W-1:0] target;
        logic [`FSPSC_ADDR_W-1:0] pc;
    } fspsc_req_t;
    typedef enum logic [1:0] {
        FSPSC_IDLE = 2'b00,
        FSPSC_CONC = 2'b01,
        FSPSC_HALT = 2'b10
    } fspsc_state_t;
endpackage

//--- rtl/fspsc_region.sv
`timescale 1ns/1ns
`include "fspsc_map.svh"
module fspsc_region (
    // Fuses and addresses
    input wire logic [1:0] boot_size_fuses,
    input wire logic [`FSPSC_ADDR_W-1:0] pc,
    input wire logic [`FSPSC_ADDR_W-1:0] target,
    // Classification
    output logic pc_in_boot,
    output logic target_in_boot,
    output logic target_in_halt
);
    logic [`FSPSC_ADDR_W-1:0] boot_base;
    // every base lies at or above the fixed halting base
    assign boot_base = (boot_size_fuses == 2'h3) ? `FSPSC_BOOT_BASE_0 :
                       (boot_size_fuses == 2'h2) ? `FSPSC_BOOT_BASE_1 :
                       (boot_size_fuses == 2'h1) ? `FSPSC_BOOT_BASE_2 :
                       `FSPSC_BOOT_BASE_3;
    assign pc_in_boot = pc >= boot_base;
    assign target_in_boot = target >= boot_base;
    assign target_in_halt = target >= `FSPSC_HALT_BASE;
endmodule

//--- rtl/fspsc_ctrl.sv
`timescale 1ns/1ns
`include "fspsc_map.svh"
// Overview of operation
// - Ignore stores issued from application region
// - Boot code may target any address
// - Boot size fuses set region boundary
// - Lock set zero guards application region
// - Lock set one guards boot region
// - Target address picks stall or concurrency
// - Fixed halting boundary independent of fuses
// - Concurrent programming keeps CPU running
// - Halting programming stalls CPU throughout
// - Block concurrent region reads while busy
// - Boot region always inside halting region
// - Busy flag high while region blocked
// - Unprogrammed application locks allow everything
module fspsc_ctrl
    import fspsc_pkg::*;
#(
    parameter int PROG_CYC = `FSPSC_PROG_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Configuration
    input wire logic [1:0] boot_size_fuses,
    input wire logic [1:0] app_lock_bits,
    input wire logic [1:0] boot_lock_bits,
    // CPU store request
    input fspsc_pkg::fspsc_req_t store_program_instr,
    input wire logic busy_flag_clear,
    // CPU fetch
    input wire logic [`FSPSC_ADDR_W-1:0] fetch_addr,
    // Status
    output logic cpu_stall,
    output logic concurrent_region_busy_flag,
    output logic fetch_valid,
    output logic op_accepted,
    output logic op_done
);
    import fspsc_pkg::*;

    // ------------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------------
    logic pc_in_boot;
    logic target_in_boot;
    logic target_in_halt;
    logic lock_ok;
    logic start;
    fspsc_state_t state;
    fspsc_state_t next_state;
    logic [`FSPSC_CNT_W-1:0] cnt;
    logic cnt_end;

    fspsc_region u_region (
        .boot_size_fuses(boot_size_fuses),
        .pc(store_program_instr.pc),
        .target(store_program_instr.target),
        .pc_in_boot(pc_in_boot),
        .target_in_boot(target_in_boot),
        .target_in_halt(target_in_halt)
    );

    // write lock check; a clear low bit forbids stores
    assign lock_ok = target_in_boot ?
        (boot_lock_bits[0] != `FSPSC_LOCK_NOWR) :
        (app_lock_bits[0] != `FSPSC_LOCK_NOWR);
    // only boot code starts, any target
    assign start = store_program_instr.valid && pc_in_boot && lock_ok &&
                   (state == FSPSC_IDLE);
    assign op_accepted = start;
    assign cnt_end = cnt == `FSPSC_CNT_W'(PROG_CYC - 1);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            FSPSC_IDLE: begin
                if (start) begin
                    next_state = target_in_halt ? FSPSC_HALT : FSPSC_CONC;
                end
            end
            FSPSC_CONC, FSPSC_HALT: begin
                if (cnt_end) begin
                    next_state = FSPSC_IDLE;
                end
            end
            default: next_state = FSPSC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= FSPSC_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= (state == FSPSC_IDLE) ? '0 : cnt + 1'b1;
        end
    end

    assign op_done = (state != FSPSC_IDLE) && cnt_end;

    // stall during halting op only, freed at its end
    // Stall also covers the start cycle so the next fetch waits
    assign cpu_stall = (state == FSPSC_HALT) ||
                       (start && target_in_halt);

    // ------------------------------------------------------------------
    // Busy flag
    // ------------------------------------------------------------------
    logic busy;
    // set on start wins over the software clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else if (start && !target_in_halt) begin
            busy <= 1'b1;
        end else if (busy_flag_clear && state != FSPSC_CONC) begin
            busy <= 1'b0;
        end
    end
    // visible in the start cycle itself
    assign concurrent_region_busy_flag = busy ||
                                         (start && !target_in_halt);

    // concurrent reads only from halting region
    assign fetch_valid = !cpu_stall &&
        (!concurrent_region_busy_flag ||
         fetch_addr >= `FSPSC_HALT_BASE);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_app_ignored;
        @(posedge core_clk) disable iff (!rstn)
        (store_program_instr.valid && !pc_in_boot) |-> !op_accepted;
    endproperty
    a_app_ignored: assert property (p_app_ignored)
        else $error("store from application region accepted");

    property p_halt_stall;
        @(posedge core_clk) disable iff (!rstn)
        (op_accepted && target_in_halt) |=> cpu_stall until op_done;
    endproperty
    a_halt_stall: assert property (p_halt_stall)
        else $error("stall dropped during halting operation");

    property p_conc_run;
        @(posedge core_clk) disable iff (!rstn)
        (state == FSPSC_CONC) |-> !cpu_stall;
    endproperty
    a_conc_run: assert property (p_conc_run)
        else $error("cpu stalled during concurrent operation");

    property p_busy_rise;
        @(posedge core_clk) disable iff (!rstn)
        (op_accepted && !target_in_halt) |-> concurrent_region_busy_flag;
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("busy flag late");

    property p_busy_hold;
        @(posedge core_clk) disable iff (!rstn)
        (state == FSPSC_CONC) |-> concurrent_region_busy_flag;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy flag low while region blocked");

    property p_block_read;
        @(posedge core_clk) disable iff (!rstn)
        (concurrent_region_busy_flag && fetch_addr < `FSPSC_HALT_BASE)
            |-> !fetch_valid;
    endproperty
    a_block_read: assert property (p_block_read)
        else $error("read of busy concurrent region served");

    property p_release;
        @(posedge core_clk) disable iff (!rstn)
        (op_done && state == FSPSC_HALT) |=> !cpu_stall || op_accepted;
    endproperty
    a_release: assert property (p_release)
        else $error("stall not released");

    property p_lock;
        @(posedge core_clk) disable iff (!rstn)
        (store_program_instr.valid && !target_in_boot &&
         !app_lock_bits[0]) |-> !op_accepted;
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked application region written");

    property p_boot_lock;
        @(posedge core_clk) disable iff (!rstn)
        (store_program_instr.valid && target_in_boot &&
         !boot_lock_bits[0]) |-> !op_accepted;
    endproperty
    a_boot_lock: assert property (p_boot_lock)
        else $error("locked boot region written");

    property p_boot_in_halt;
        @(posedge core_clk) disable iff (!rstn)
        target_in_boot |-> target_in_halt;
    endproperty
    a_boot_in_halt: assert property (p_boot_in_halt)
        else $error("boot region reaches below halting region");

    property p_app_free;
        @(posedge core_clk) disable iff (!rstn)
        (store_program_instr.valid && pc_in_boot && !target_in_boot &&
         app_lock_bits == `FSPSC_LOCK_FREE && state == FSPSC_IDLE)
            |-> op_accepted;
    endproperty
    a_app_free: assert property (p_app_free)
        else $error("free application region store refused");

    property p_any_target;
        @(posedge core_clk) disable iff (!rstn)
        (store_program_instr.valid && pc_in_boot && target_in_boot &&
         boot_lock_bits[0] && state == FSPSC_IDLE) |-> op_accepted;
    endproperty
    a_any_target: assert property (p_any_target)
        else $error("boot code store to boot region refused");

    property p_mode;
        @(posedge core_clk) disable iff (!rstn)
        (op_accepted && !target_in_halt) |=> state == FSPSC_CONC;
    endproperty
    a_mode: assert property (p_mode)
        else $error("concurrent target did not run concurrently");
endmodule

//--- tb/fspsc_cpu.sv
`timescale 1ns/1ns
`include "fspsc_map.svh"
module fspsc_cpu (
    // Bench commands
    input wire logic go,
    input wire logic [`FSPSC_ADDR_W-1:0] pc,
    input wire logic [`FSPSC_ADDR_W-1:0] target,
    input wire logic clr,
    // Core side
    output fspsc_pkg::fspsc_req_t store_program_instr,
    output logic busy_flag_clear
);
    import fspsc_pkg::*;
    // ----------------------------------------
    // Store issue
    // ----------------------------------------
    // fetch stays out
    // Bench aims most fetches at the halting region and one at the busy region to probe blocking
    assign store_program_instr = '{go, 1'b0, target, pc};
    assign busy_flag_clear = clr;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
`include "fspsc_map.svh"
module tb_top;
    import fspsc_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] fuses = 2'h3;
    logic [1:0] app_lk = 2'h3;
    logic [1:0] boot_lk = 2'h3;
    logic go = 1'b0;
    logic clr = 1'b0;
    logic [11:0] pc = 12'h000;
    logic [11:0] tgt = 12'h000;
    logic [11:0] fa = 12'h000;
    fspsc_req_t req;
    logic bclr, stall, busy, fv, acc, done;
    int failures = 0;
    int n_checks = 0;
    localparam int PROG = 8;
    always #20 core_clk = ~core_clk;
    fspsc_cpu cpu (.go(go), .pc(pc), .target(tgt), .clr(clr),
        .store_program_instr(req), .busy_flag_clear(bclr));
    fspsc_ctrl #(.PROG_CYC(PROG)) dut (.core_clk(core_clk), .rstn(rstn),
        .boot_size_fuses(fuses), .app_lock_bits(app_lk),
        .boot_lock_bits(boot_lk), .store_program_instr(req),
        .busy_flag_clear(bclr), .fetch_addr(fa), .cpu_stall(stall),
        .concurrent_region_busy_flag(busy), .fetch_valid(fv),
        .op_accepted(acc), .op_done(done));
    // ----------------------------------------
    // Checking and verdict
    // ----------------------------------------
    task automatic close_out;
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %b got %b", nm, e, g);
        end
    endtask
    // One store request; a accepted, h halting; waits out the op
    task automatic run(input logic [11:0] p, t, f, input logic a, h);
        int n;
        @(posedge core_clk);
        #1;
        go = 1'b1;
        clr = 1'b1;
        pc = p;
        tgt = t;
        fa = f;
        #1 chk("accept", a, acc);
        chk("stall", a & h, stall);
        chk("busy", a & ~h, busy);
        chk("fetch", ~(a & h) & ~(a & ~h & (f < `FSPSC_HALT_BASE)),
            fv);
        @(posedge core_clk);
        #1;
        go = 1'b0;
        clr = 1'b0;
        chk("set_wins", a & ~h, busy);
        if (a) begin
            n = 1;
            while (done !== 1'b1 && n < 20) begin
                @(posedge core_clk);
                #1;
                n++;
                if (n == 2) begin
                    go = 1'b1;
                    clr = 1'b1;
                    #1 chk("refused_busy", 1'b0, acc);
                    chk("mid_stall", h, stall);
                    chk("mid_busy", ~h, busy);
                    chk("mid_fetch", ~h & (f >= `FSPSC_HALT_BASE), fv);
                end else begin
                    go = 1'b0;
                    clr = 1'b0;
                end
                if (n == 3) begin
                    chk("busy_kept", ~h, busy);
                end
            end
            chk("length", 1'b1, n == PROG);
            if (n == 20) close_out();
            @(posedge core_clk);
            #1;
            chk("release", 1'b0, stall);
            chk("done_pulse", 1'b0, done);
            chk("flag_held", ~h, busy);
            clr = 1'b1;
            @(posedge core_clk);
            #1;
            clr = 1'b0;
            chk("flag_cleared", 1'b0, busy);
        end
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        #1;
        chk("reset_stall", 1'b0, stall);
        chk("reset_busy", 1'b0, busy);
        rstn = 1'b1;
        run(12'h100, 12'h010, 12'hC10, 1'b0, 1'b0);
        run(12'hF80, 12'h010, 12'hC10, 1'b1, 1'b0);
        run(12'hF80, 12'h010, 12'h010, 1'b1, 1'b0);
        run(12'hF80, 12'hF90, 12'hC10, 1'b1, 1'b1);
        run(12'hF80, 12'hC40, 12'hC10, 1'b1, 1'b1);
        run(12'hE00, 12'h010, 12'hC10, 1'b0, 1'b0);
        fuses = 2'h1;
        run(12'hE00, 12'hD00, 12'hC10, 1'b1, 1'b1);
        fuses = 2'h0;
        run(12'hC00, 12'hB00, 12'hC10, 1'b1, 1'b0);
        fuses = 2'h3;
        app_lk = 2'h2;
        run(12'hF80, 12'h010, 12'hC10, 1'b0, 1'b0);
        app_lk = 2'h3;
        boot_lk = 2'h2;
        run(12'hF80, 12'hF90, 12'hC10, 1'b0, 1'b0);
        run(12'hF80, 12'h010, 12'hC10, 1'b1, 1'b0);
        // Reset in the middle of a halting operation
        boot_lk = 2'h3;
        @(posedge core_clk);
        #1;
        go = 1'b1;
        pc = 12'hF80;
        tgt = 12'hF90;
        @(posedge core_clk);
        #1;
        go = 1'b0;
        rstn = 1'b0;
        #1 chk("abort_stall", 1'b0, stall);
        chk("abort_busy", 1'b0, busy);
        @(posedge core_clk);
        #1;
        rstn = 1'b1;
        run(12'hF80, 12'h010, 12'hC10, 1'b1, 1'b0);
        close_out();
    end
endmodule
